// >>> verilog/ebra_pkg.sv
package ebra_pkg;
    // ==========================================
    // Register bus and external bus geometry
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 16;
    localparam int BUS_ADDR_W = 16;
    localparam int BUS_DATA_W = 16;

    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;

    // ==========================================
    // Configuration fields
    localparam int CFG_MEMWS_LSB = 0;
    localparam int CFG_MEMWS_W = 4;
    localparam int CFG_RWDLY_BIT = 4;
    localparam int CFG_MUX_BIT = 5;
    localparam int CFG_TRI_BIT = 6;
    localparam int CFG_RDYEN_BIT = 7;
    localparam int CFG_USED_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ==========================================
    // Command and status fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_GRANT_BIT = 1;
    localparam int STAT_REGAIN_BIT = 2;
    localparam int STAT_STATE_LSB = 4;

    // ==========================================
    // Pin synchroniser
    localparam int SYNC_W = 2;
    localparam int SYNC_READY = 0;
    localparam int SYNC_HOLD = 1;
    localparam logic [1:0] SYNC_RESET = 2'h3;

    // ==========================================
    // Bus cycle state machine
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_DELAY = 4'h2,
        ST_CMD = 4'h3,
        ST_READY = 4'h4,
        ST_MUXWS = 4'h5,
        ST_TRIWS = 4'h6,
        ST_HOLD = 4'h7,
        ST_REGAIN = 4'h8
    } ebra_state_t;
endpackage

// >>> verilog/ebra_pin_if.sv
`timescale 1ns/1ns
// Raw pin levels in, filtered levels out
interface ebra_pin_if;
    logic [1:0] rawLevel;
    logic [1:0] cleanLevel;
    modport sync (input rawLevel, output cleanLevel);
    modport core (output rawLevel, input cleanLevel);
endinterface

// >>> verilog/ebra_pin_sync.sv
`timescale 1ns/1ns
module ebra_pin_sync
    import ebra_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    ebra_pin_if.sync pins
);
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
    logic [SYNC_W-1:0] stage3;
    logic [SYNC_W-1:0] level;
    logic [SYNC_W-1:0] next_level;

    // ==========================================
    // Accept a change once stages two and three agree
    assign next_level = (stage2 & stage3) | (level & (stage2 | stage3));
    assign pins.cleanLevel = level;

    // Three-stage chain, reset to inactive high
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stage1 <= SYNC_RESET;
            stage2 <= SYNC_RESET;
            stage3 <= SYNC_RESET;
            level <= SYNC_RESET;
        end else begin
            stage1 <= pins.rawLevel;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule

// >>> verilog/ebra_bus_ctrl.sv
`timescale 1ns/1ns
module ebra_bus_ctrl
    import ebra_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [REG_DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [REG_DATA_W-1:0] regRdData,
    output logic busClockOutput,
    output logic [BUS_ADDR_W-1:0] busAddr,
    input wire logic [BUS_DATA_W-1:0] busDataIn,
    output logic [BUS_DATA_W-1:0] busDataOut,
    output logic busDataOe_n,
    output logic busCtrlOe_n,
    output logic addrLatch,
    output logic readStrobe_n,
    output logic writeStrobe_n,
    output logic chipSelect_n,
    output logic chipSelectOe_n,
    input wire logic ready_n,
    input wire logic holdRequest_n,
    output logic busGrantAck_n,
    output logic regainRequestOut_n
);
    // ==========================================
    // Declarations
    ebra_state_t state;
    ebra_state_t next_state;
    logic [CFG_USED_W-1:0] cfg;
    logic [BUS_ADDR_W-1:0] cycleAddr;
    logic [BUS_DATA_W-1:0] cycleWrData;
    logic [BUS_DATA_W-1:0] lastRead;
    logic [CFG_MEMWS_W-1:0] wsCount;
    logic [CFG_MEMWS_W-1:0] next_wsCount;
    logic pending;
    logic isWrite;
    logic busTick;
    logic endNow;
    logic readyLow;
    logic holdLow;
    logic [CFG_MEMWS_W-1:0] cfgMemWs;
    logic rwDelay;
    logic muxMode;
    logic triWs;
    logic readyEn;
    ebra_state_t afterEnd;
    logic selCfg;
    logic selAddr;
    logic selWdata;
    logic selCmd;
    logic selStatus;
    logic selRdata;
    logic startReq;
    logic [REG_DATA_W-1:0] statusWord;
    logic [REG_DATA_W-1:0] next_rdData;

    // ==========================================
    // State classification helpers
    function automatic logic inCycle(input ebra_state_t s);
        return (s == ST_ADDR) || (s == ST_DELAY) || (s == ST_CMD) || (s == ST_READY);
    endfunction

    function automatic logic strobing(input ebra_state_t s);
        return (s == ST_CMD) || (s == ST_READY);
    endfunction

    function automatic logic released(input ebra_state_t s);
        return (s == ST_HOLD) || (s == ST_REGAIN);
    endfunction

    // ==========================================
    // Pin synchronisers for ready and hold
    ebra_pin_if pinIf ();
    assign pinIf.rawLevel[SYNC_READY] = ready_n;
    assign pinIf.rawLevel[SYNC_HOLD] = holdRequest_n;
    assign readyLow = ~pinIf.cleanLevel[SYNC_READY];
    assign holdLow = ~pinIf.cleanLevel[SYNC_HOLD];

    ebra_pin_sync pinSync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pins(pinIf.sync)
    );

    // ==========================================
    // Configuration field decode
    assign cfgMemWs = cfg[CFG_MEMWS_LSB +: CFG_MEMWS_W];
    assign rwDelay = cfg[CFG_RWDLY_BIT];
    assign muxMode = cfg[CFG_MUX_BIT];
    assign triWs = cfg[CFG_TRI_BIT];
    assign readyEn = cfg[CFG_RDYEN_BIT];

    // Bus state advances on rising edges of the bus clock
    assign busTick = ~busClockOutput;

    // Trailing waitstates after a terminated cycle
    assign afterEnd = muxMode ? ST_MUXWS : (triWs ? ST_TRIWS : ST_IDLE);

    // Cycle ends on this edge
    assign endNow = busTick && strobing(state) && !strobing(next_state);

    // ==========================================
    // Next state
    always_comb begin
        next_state = state;
        next_wsCount = wsCount;
        if (busTick) begin
            case (state)
                ST_IDLE: begin
                    if (holdLow) begin
                        next_state = ST_HOLD;
                    end else if (pending) begin
                        next_state = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    next_wsCount = cfgMemWs;
                    next_state = rwDelay ? ST_DELAY : ST_CMD;
                end
                ST_DELAY: begin
                    next_state = ST_CMD;
                end
                ST_CMD: begin
                    if (wsCount != '0) begin
                        next_wsCount = wsCount - 1'b1;
                    end else if (readyEn && !readyLow) begin
                        next_state = ST_READY;
                    end else begin
                        next_state = afterEnd;
                    end
                end
                ST_READY: begin
                    if (readyLow) begin
                        next_state = afterEnd;
                    end
                end
                ST_MUXWS: begin
                    next_state = triWs ? ST_TRIWS : ST_IDLE;
                end
                ST_TRIWS: begin
                    next_state = ST_IDLE;
                end
                ST_HOLD: begin
                    if (!holdLow) begin
                        next_state = ST_REGAIN;
                    end
                end
                ST_REGAIN: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // State and bus clock divider
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            wsCount <= '0;
            busClockOutput <= 1'b0;
        end else begin
            state <= next_state;
            wsCount <= next_wsCount;
            busClockOutput <= ~busClockOutput;
        end
    end

    // ==========================================
    // Pin outputs registered; control pins from the next state, address and write data from the cycle registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addrLatch <= 1'b0;
            readStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            chipSelect_n <= 1'b1;
            chipSelectOe_n <= 1'b0;
            busCtrlOe_n <= 1'b0;
            busDataOe_n <= 1'b1;
            busGrantAck_n <= 1'b1;
            regainRequestOut_n <= 1'b1;
            busAddr <= '0;
            busDataOut <= '0;
        end else begin
            addrLatch <= (next_state == ST_ADDR);
            readStrobe_n <= ~(strobing(next_state) && !isWrite);
            writeStrobe_n <= ~(strobing(next_state) && isWrite);
            chipSelect_n <= ~inCycle(next_state);
            chipSelectOe_n <= released(next_state);
            busCtrlOe_n <= released(next_state);
            busDataOe_n <= ~(inCycle(next_state) && isWrite);
            busGrantAck_n <= ~(next_state == ST_HOLD);
            regainRequestOut_n <= ~((next_state == ST_HOLD) && pending);
            busAddr <= cycleAddr;
            busDataOut <= cycleWrData;
        end
    end

    // ==========================================
    // Register decode
    assign selCfg = (regAddr == REG_CFG);
    assign selAddr = (regAddr == REG_ADDR);
    assign selWdata = (regAddr == REG_WDATA);
    assign selCmd = (regAddr == REG_CMD);
    assign selStatus = (regAddr == REG_STATUS);
    assign selRdata = (regAddr == REG_RDATA);
    assign startReq = regWrite && selCmd && regWrData[CMD_START_BIT] && !pending;

    assign statusWord = {8'h00, state, 1'b0, ~regainRequestOut_n,
        ~busGrantAck_n, pending};

    // Read data mux, zero for unmapped offsets
    assign next_rdData = !regRead ? '0 :
        selCfg ? {8'h00, cfg} :
        selAddr ? cycleAddr :
        selWdata ? cycleWrData :
        selStatus ? statusWord :
        selRdata ? lastRead : '0;

    // Software registers and pending cycle request
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg <= CFG_RESET;
            cycleAddr <= '0;
            cycleWrData <= '0;
            pending <= 1'b0;
            isWrite <= 1'b0;
            regRdData <= '0;
        end else begin
            regRdData <= next_rdData;
            if (regWrite && selCfg && !inCycle(state)) begin
                cfg <= regWrData[CFG_USED_W-1:0];
            end
            if (regWrite && selAddr && !pending) begin
                cycleAddr <= regWrData;
            end
            if (regWrite && selWdata && !pending) begin
                cycleWrData <= regWrData;
            end
            if (startReq) begin
                pending <= 1'b1;
                isWrite <= regWrData[CMD_WRITE_BIT];
            end else if (endNow) begin
                pending <= 1'b0;
            end
        end
    end

    // Read data taken on the terminating edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            lastRead <= '0;
        end else if (endNow && !isWrite) begin
            lastRead <= busDataIn;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    chk_ready_wait_state: assert property (
        (state == ST_READY && busTick && !readyLow) |=> (state == ST_READY) && !readStrobe_n
            || (state == ST_READY) && !writeStrobe_n)
        else $error("ready high did not hold the cycle");

    chk_ready_end_cycle: assert property (
        (state == ST_READY && busTick && readyLow) |=> !strobing(state) && readStrobe_n
            && writeStrobe_n)
        else $error("ready low did not end the cycle");

    chk_ws_count_load: assert property (
        (state == ST_ADDR && busTick) |=> (wsCount == $past(cfgMemWs)))
        else $error("waitstate count not loaded");

    chk_ws_count_stay: assert property (
        (state == ST_CMD && busTick && wsCount != '0) |=> (state == ST_CMD)
            && (wsCount == $past(wsCount) - 1'b1) ##1 (state == ST_CMD))
        else $error("waitstate cycle cut short");

    chk_rw_delay_edge: assert property (
        (state == ST_ADDR && busTick && rwDelay) |=> readStrobe_n && writeStrobe_n ##2
            (state == ST_CMD) && !(readStrobe_n && writeStrobe_n))
        else $error("command delay not honoured");

    chk_mux_tri_gap: assert property (
        (endNow && muxMode && triWs) |=> (state == ST_MUXWS) ##2 (state == ST_TRIWS) ##2
            (state == ST_IDLE))
        else $error("multiplexed gap not two bus clocks");

    chk_demux_no_gap: assert property (
        (endNow && !muxMode && !triWs) |=> (state == ST_IDLE))
        else $error("demultiplexed gap not zero");

    chk_grant_after_cycle: assert property (
        $fell(busGrantAck_n) |-> (state == ST_HOLD) && ($past(state) == ST_IDLE))
        else $error("bus granted during a cycle");

    chk_cs_released: assert property (
        (state == ST_HOLD) |-> chipSelectOe_n && busCtrlOe_n)
        else $error("chip select driven while granted");

    chk_regain_after_ack: assert property (
        !regainRequestOut_n |-> (state == ST_HOLD) && !busGrantAck_n)
        else $error("regain request before grant");

    chk_hold_keeps_grant: assert property (
        (state == ST_HOLD && holdLow) |=> (state == ST_HOLD) && !busGrantAck_n)
        else $error("regain started without hold withdrawal");

    chk_regain_sequence: assert property (
        (state == ST_HOLD && busTick && !holdLow) |=> busGrantAck_n && chipSelectOe_n ##2
            (state == ST_IDLE) && !chipSelectOe_n)
        else $error("acknowledge not removed before driving");

    chk_read_capture: assert property (
        (endNow && !isWrite) |=> (lastRead == $past(busDataIn)))
        else $error("read data not captured at termination");

    cov_ready_wait: cover property (state == ST_READY && busTick && !readyLow);
    cov_hold_grant: cover property ($fell(busGrantAck_n));
    cov_regain_req: cover property ($fell(regainRequestOut_n));
    cov_mux_trail: cover property (state == ST_TRIWS && muxMode);
endmodule

// >>> test/ebra_bus_partner.sv
`timescale 1ns/1ns
// ==========================================
// Memory and slow peripheral on the far side of the bus
module ebra_bus_partner
    import ebra_pkg::*;
(
    input wire logic clk_sys,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic [BUS_DATA_W-1:0] memWord,
    input wire logic [7:0] readyDelay,
    output logic [BUS_DATA_W-1:0] busDataIn,
    output logic ready_n
);
    logic [7:0] lowCount;
    wire cmdActive = !readStrobe_n || !writeStrobe_n;

    // Data only while read command is low, inverse pattern otherwise
    assign busDataIn = readStrobe_n ? ~memWord : memWord;

    // Ready low after a chosen delay, removed when the command rises
    initial begin
        ready_n = 1'h1;
        lowCount = 8'h00;
        forever begin
            @(posedge clk_sys);
            if (!cmdActive) begin
                lowCount <= 8'h00;
                ready_n <= 1'h1;
            end else begin
                if (lowCount != 8'hFF) begin
                    lowCount <= lowCount + 8'h01;
                end
                ready_n <= (lowCount < readyDelay);
            end
        end
    end
endmodule

// >>> test/ext_bus_ready_and_arbitration_test.sv
`timescale 1ns/1ns
module ext_bus_ready_and_arbitration_test;
    import ebra_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic [7:0] regAddr;
    logic [15:0] regWrData;
    logic regWrite;
    logic regRead;
    logic [15:0] regRdData;
    logic [15:0] busAddr;
    logic [15:0] busDataIn;
    logic [15:0] busDataOut;
    logic busDataOe_n;
    logic busClockOutput;
    logic busCtrlOe_n;
    logic addrLatch;
    logic readStrobe_n;
    logic writeStrobe_n;
    logic chipSelect_n;
    logic chipSelectOe_n;
    logic ready_n;
    logic holdRequest_n;
    logic busGrantAck_n;
    logic regainRequestOut_n;
    logic [15:0] memWord;
    logic [7:0] readyDelay;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] trailCfg [4] = '{8'h00, 8'h20, 8'h40, 8'h60};
    int trailExp [4] = '{0, 1, 1, 2};

    ebra_bus_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .busClockOutput(busClockOutput), .busAddr(busAddr),
        .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe_n(busDataOe_n),
        .busCtrlOe_n(busCtrlOe_n), .addrLatch(addrLatch), .readStrobe_n(readStrobe_n),
        .writeStrobe_n(writeStrobe_n), .chipSelect_n(chipSelect_n),
        .chipSelectOe_n(chipSelectOe_n), .ready_n(ready_n),
        .holdRequest_n(holdRequest_n), .busGrantAck_n(busGrantAck_n),
        .regainRequestOut_n(regainRequestOut_n));

    ebra_bus_partner far (.clk_sys(clk_sys), .readStrobe_n(readStrobe_n),
        .writeStrobe_n(writeStrobe_n), .memWord(memWord), .readyDelay(readyDelay),
        .busDataIn(busDataIn), .ready_n(ready_n));

    // ==========================================
    // Clock
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================
    // Compare, report and wait helpers
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        checkVal({15'h0000, got}, {15'h0000, exp});
    endtask

    function automatic logic sigVal(input int sel);
        case (sel)
            0: return readStrobe_n;
            1: return writeStrobe_n;
            2: return addrLatch;
            3: return busGrantAck_n;
            4: return chipSelect_n;
            5: return regainRequestOut_n;
            default: return chipSelectOe_n;
        endcase
    endfunction

    // Counts settled cycles until a pin reaches a level
    task automatic waitLevel(input int sel, input logic lvl, output int n);
        n = 0;
        while (sigVal(sel) !== lvl) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 600) begin
                mismatches++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, sel, lvl);
                summarize();
            end
        end
    endtask

    // ==========================================
    // Register bus master
    task automatic regWr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'h1;
        @(posedge clk_sys);
        regWrite <= 1'h0;
    endtask

    task automatic regRd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk_sys);
        regRead <= 1'h0;
        #1;
        d = regRdData;
    endtask

    // ==========================================
    // Scenarios
    task automatic testRegs();
        logic [15:0] d;
        logic clkLvl;
        @(posedge clk_sys);
        #1;
        clkLvl = busClockOutput;
        @(posedge clk_sys);
        #1;
        checkBit(busClockOutput, ~clkLvl);
        regRd(REG_CFG, d);
        checkVal(d, 16'h0000);
        regRd(8'hFC, d);
        checkVal(d, 16'h0000);
        regRd(REG_STATUS, d);
        checkVal(d, 16'h0000);
        checkBit(busGrantAck_n, 1'h1);
        checkBit(chipSelectOe_n, 1'h0);
        checkBit(busCtrlOe_n, 1'h0);
    endtask

    // One bus cycle; lead, command length and trailing ticks are measured
    task automatic busCycle(input logic wr, input logic [7:0] cfg,
                            output int lead, output int len, output int trail);
        logic [15:0] d;
        int n;
        @(posedge clk_sys);
        memWord <= {8'h5A, cfg};
        regWr(REG_CFG, {8'h00, cfg});
        regWr(REG_ADDR, {8'h12, cfg});
        regWr(REG_WDATA, {cfg, 8'hC3});
        regWr(REG_CMD, {14'h0000, wr, 1'h1});
        waitLevel(2, 1'h1, n);
        waitLevel(wr ? 1 : 0, 1'h0, lead);
        checkVal(busAddr, {8'h12, cfg});
        if (wr) begin
            checkVal(busDataOut, {cfg, 8'hC3});
            checkBit(busDataOe_n, 1'h0);
        end else begin
            checkBit(busDataOe_n, 1'h1);
        end
        checkBit(wr ? readStrobe_n : writeStrobe_n, 1'h1);
        waitLevel(wr ? 1 : 0, 1'h1, len);
        trail = 0;
        regRd(REG_STATUS, d);
        while (d[7:4] !== 4'h0 && trail < 8) begin
            trail++;
            regRd(REG_STATUS, d);
        end
        checkBit(d[0], 1'h0);
        if (!wr) begin
            regRd(REG_RDATA, d);
            checkVal(d, {8'h5A, cfg});
        end
    endtask

    task automatic checkCycle(input logic wr, input logic [7:0] cfg, input int expLead,
                              input int expLen, input int expTrail);
        int lead;
        int len;
        int trail;
        busCycle(wr, cfg, lead, len, trail);
        checkVal(lead[15:0], expLead[15:0]);
        checkVal(len[15:0], expLen[15:0]);
        checkVal(trail[15:0], expTrail[15:0]);
    endtask

    task automatic testReady();
        int lead;
        int len;
        int trail;
        @(posedge clk_sys);
        readyDelay <= 8'h0C;
        busCycle(1'h0, 8'h80, lead, len, trail);
        checkBit(len > 12, 1'h1);
        checkBit(len <= 24, 1'h1);
        @(posedge clk_sys);
        readyDelay <= 8'h00;
    endtask

    // External master takes the bus, with or without a pending own cycle
    task automatic testHold(input logic withPending);
        int n;
        regWr(REG_CFG, 16'h000F);
        regWr(REG_CMD, 16'h0001);
        waitLevel(4, 1'h0, n);
        @(posedge clk_sys);
        holdRequest_n <= 1'h0;
        repeat (12) @(posedge clk_sys);
        #1;
        checkBit(busGrantAck_n, 1'h1);
        checkBit(chipSelect_n, 1'h0);
        waitLevel(3, 1'h0, n);
        checkBit(chipSelectOe_n, 1'h1);
        checkBit(busCtrlOe_n, 1'h1);
        checkBit(regainRequestOut_n, 1'h1);
        if (withPending) begin
            regWr(REG_CMD, 16'h0001);
            waitLevel(5, 1'h0, n);
        end
        repeat (30) @(posedge clk_sys);
        #1;
        checkBit(busGrantAck_n, 1'h0);
        checkBit(regainRequestOut_n, !withPending);
        @(posedge clk_sys);
        holdRequest_n <= 1'h1;
        waitLevel(3, 1'h1, n);
        checkBit(chipSelectOe_n, 1'h1);
        waitLevel(6, 1'h0, n);
        checkBit(busCtrlOe_n, 1'h0);
        checkBit(regainRequestOut_n, 1'h1);
        if (withPending) begin
            waitLevel(2, 1'h1, n);
            checkBit(busGrantAck_n, 1'h1);
            waitLevel(0, 1'h0, n);
            waitLevel(0, 1'h1, n);
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        reset_n = 1'h0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWrite = 1'h0;
        regRead = 1'h0;
        holdRequest_n = 1'h1;
        memWord = 16'h0000;
        readyDelay = 8'h00;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'h1;
        testRegs();
        checkCycle(1'h0, 8'h00, 2, 2, 0);
        checkCycle(1'h0, 8'h03, 2, 8, 0);
        checkCycle(1'h0, 8'h10, 4, 2, 0);
        checkCycle(1'h1, 8'h11, 4, 4, 0);
        foreach (trailCfg[i]) begin
            checkCycle(1'h0, trailCfg[i], 2, 2, trailExp[i]);
        end
        testReady();
        testHold(1'h1);
        testHold(1'h0);
        summarize();
    end
endmodule
